// ==== include/ldor_pkg.sv ====
// package: indices, reset values, field layouts and masks of the option register bank
package ldor_pkg;
	// logical device numbers
	localparam logic [7:0] LDN_FLOPPY  = 8'h00;
	localparam logic [7:0] LDN_PRINTER = 8'h03;
	localparam logic [7:0] LDN_SERIAL1 = 8'h04;
	// register indices
	localparam logic [7:0] IDX_FLOPPY_MODE_CTRL   = 8'hf0;
	localparam logic [7:0] IDX_FLOPPY_OPTION_CTRL = 8'hf1;
	localparam logic [7:0] IDX_FLOPPY_DRIVE_TYPE  = 8'hf2;
	localparam logic [7:0] IDX_FLOPPY_RSVD_ZERO   = 8'hf3;
	localparam logic [7:0] IDX_DRIVE0_PARAMS      = 8'hf4;
	localparam logic [7:0] IDX_DRIVE1_PARAMS      = 8'hf5;
	localparam logic [7:0] IDX_PRINTER_PORT_MODE  = 8'hf0;
	localparam logic [7:0] IDX_PRINTER_PORT_MODE2 = 8'hf1;
	localparam logic [7:0] IDX_SERIAL_ONE_MODE    = 8'hf0;
	// reset values
	localparam logic [7:0] RST_FLOPPY_MODE   = 8'h0e;
	localparam logic [7:0] RST_FLOPPY_OPTION = 8'h00;
	localparam logic [7:0] RST_DRIVE_TYPE    = 8'hff;
	localparam logic [7:0] RST_DRIVE_PARAMS  = 8'h00;
	localparam logic [7:0] RST_PP_MODE       = 8'h3c;
	localparam logic [7:0] RST_PP_MODE2      = 8'h00;
	localparam logic [7:0] RST_SERIAL_ONE    = 8'h00;
	// writable-bit masks; cleared bits are reserved and read zero
	localparam logic [7:0] MSK_FLOPPY_MODE   = 8'hcf;
	localparam logic [7:0] MSK_FLOPPY_OPTION = 8'h0d;
	localparam logic [7:0] MSK_DRIVE_TYPE    = 8'hff;
	localparam logic [7:0] MSK_DRIVE_PARAMS  = 8'h5b;
	localparam logic [7:0] MSK_PP_MODE       = 8'hff;
	localparam logic [7:0] MSK_PP_MODE2      = 8'h10;
	localparam logic [7:0] MSK_SERIAL_ONE    = 8'h83;
	// field positions
	localparam int FM_ENHANCED = 0;
	localparam int FM_NONBURST = 1;
	localparam int FM_IFACE_LO = 2;
	localparam int FM_PUSHPULL = 6;
	localparam int FM_TRISTATE = 7;
	localparam int FO_FORCE_WP = 0;
	localparam int FO_DENS_LO  = 2;
	localparam int DP_KIND_LO  = 0;
	localparam int DP_RATE_LO  = 3;
	localparam int DP_PRECOMP  = 6;
	localparam int PP_MODE_LO  = 0;
	localparam int PP_THR_LO   = 3;
	localparam int PP_IRQ_PULSE = 7;
	localparam int PP2_TMO_SEL = 4;
	localparam int SP_MIDI     = 0;
	localparam int SP_HISPEED  = 1;
	localparam int SP_SHARE    = 7;
	// encodings
	localparam logic [2:0] PPM_PRINTER  = 3'h4;
	localparam logic [2:0] PPM_STANDARD = 3'h0;
	localparam logic [1:0] DENS_FORCE_1 = 2'h2;
	localparam logic [1:0] DENS_FORCE_0 = 2'h3;
	localparam int FLOPPY_PINS = 4;
endpackage

// ==== verilog/ldor_regs.sv ====
// logical device option registers with the floppy, printer-port and serial-port glue they steer
// Notes on behaviour
// - bank resets only on power-on or PCI reset; soft reset leaves it alone
// - floppy mode bit 0: 0 normal, 1 enhanced mode 2
// - floppy mode bit 1: 0 burst DMA, 1 non-burst (default)
// - floppy mode bits 3:2 pick interface model, 11 default, 10 reserved
// - floppy mode bit 6: 0 open-drain outputs, 1 push-pull
// - floppy mode bit 7: 1 puts the floppy pins, not the printer-route ones, in high impedance
// - output type and tristate bits never touch floppy signals on printer pins
// - write protect is OR of forced-select terms, drive input and global bit
// - forced write protect also applies through the printer-port pins
// - option bits 3:2 steer density: 0x normal, 10 forces 1, 11 forces 0
// - drive type register: A in 1:0, B in 3:2, 7:4 storage, resets all ones
// - per-drive register: kind 1:0, rate table 4:3, precomp off bit 6
// - second per-drive register has same layout and reset as the first
// - printer mode bits 2:0 select port mode, printer mode default
// - printer mode bits 6:3 hold FIFO threshold, reset 0111
// - printer mode bit 7: pulsed-low interrupt, else follows core level
// - interrupt type bit ignored in printer and standard modes
// - timeout flag clears by write of one, or after status read ends
// - serial mode bit 0 enables MIDI, bit 1 high speed, both reset zero
// - serial mode bit 7 makes both UARTs share one interrupt
// - with share set, both interrupt outputs assert when either UART fires
`timescale 1ns/1ps
`default_nettype none
module ldor_regs (
	input  wire logic                                   clk_in,
	input  wire logic                                   nrst_in,
	input  wire logic                                   soft_reset_in,
	input  wire logic [7:0]                             cfg_ldn_in,
	input  wire logic [7:0]                             cfg_index_in,
	input  wire logic [7:0]                             cfg_wdata_in,
	input  wire logic                                   cfg_wr_in,
	input  wire logic                                   cfg_rd_in,
	output logic      [7:0]                             cfg_rdata_out,
	output logic                                        floppy_enhanced_out,
	output logic                                        floppy_nonburst_out,
	output logic      [1:0]                             floppy_iface_model_out,
	output logic      [1:0]                             drive_a_type_out,
	output logic      [1:0]                             drive_b_type_out,
	output logic      [1:0]                             drive0_kind_select_out,
	output logic      [1:0]                             drive0_rate_table_select_out,
	output logic                                        drive0_precomp_disable_out,
	output logic      [1:0]                             drive1_kind_select_out,
	output logic      [1:0]                             drive1_rate_table_select_out,
	output logic                                        drive1_precomp_disable_out,
	input  wire logic [ldor_pkg::FLOPPY_PINS-1:0]       floppy_core_pins_in,
	output logic      [ldor_pkg::FLOPPY_PINS-1:0]       floppy_pins_out,
	output logic      [ldor_pkg::FLOPPY_PINS-1:0]       floppy_pins_oe_out,
	output logic      [ldor_pkg::FLOPPY_PINS-1:0]       pp_floppy_pins_out,
	output logic      [ldor_pkg::FLOPPY_PINS-1:0]       pp_floppy_pins_oe_out,
	input  wire logic                                   floppy_on_pp_in,
	input  wire logic                                   drive_select_zero_n_in,
	input  wire logic                                   drive_select_one_n_in,
	input  wire logic                                   write_protect_in_n_in,
	input  wire logic                                   pp_drive_select_zero_n_in,
	input  wire logic                                   pp_drive_select_one_n_in,
	input  wire logic                                   pp_write_protect_in_n_in,
	input  wire logic                                   floppy_write_protect_in,
	output logic                                        core_write_protect_out,
	output logic                                        status_reg_a_wp_out,
	input  wire logic                                   density_core_in,
	output logic                                        density_out,
	output logic      [2:0]                             pp_mode_out,
	output logic      [3:0]                             pp_fifo_threshold_out,
	output logic                                        pp_irq_pulse_mode_out,
	input  wire logic                                   pp_irq_core_in,
	output logic                                        pp_irq_out,
	output logic                                        pp_irq_oe_out,
	input  wire logic                                   epp_timeout_set_in,
	input  wire logic                                   epp_status_wr_in,
	input  wire logic                                   epp_status_wdata_in,
	input  wire logic                                   epp_status_rd_in,
	output logic                                        epp_timeout_flag_out,
	output logic                                        serial_midi_out,
	output logic                                        serial_high_speed_out,
	input  wire logic                                   uart1_irq_in,
	input  wire logic                                   uart2_irq_in,
	output logic                                        uart1_irq_out,
	output logic                                        uart2_irq_out
);

	////////////////////////////////////////////////////////////////////////////////
	// register storage

	logic [7:0] fmode_reg;
	logic [7:0] fopt_reg;
	logic [7:0] ftype_reg;
	logic [7:0] drv0_reg;
	logic [7:0] drv1_reg;
	logic [7:0] ppmode_reg;
	logic [7:0] ppmode2_reg;
	logic [7:0] sp1_reg;
	logic       sel_floppy;
	logic       sel_printer;
	logic       sel_serial;

	assign sel_floppy  = cfg_wr_in && (cfg_ldn_in == ldor_pkg::LDN_FLOPPY);
	assign sel_printer = cfg_wr_in && (cfg_ldn_in == ldor_pkg::LDN_PRINTER);
	assign sel_serial  = cfg_wr_in && (cfg_ldn_in == ldor_pkg::LDN_SERIAL1);

	// only nrst_in (power-on or PCI reset) clears the bank; soft_reset_in is
	// deliberately unused here so a soft reset cannot disturb setup
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			fmode_reg <= ldor_pkg::RST_FLOPPY_MODE;
			fopt_reg  <= ldor_pkg::RST_FLOPPY_OPTION;
			ftype_reg <= ldor_pkg::RST_DRIVE_TYPE;
			drv0_reg  <= ldor_pkg::RST_DRIVE_PARAMS;
			drv1_reg  <= ldor_pkg::RST_DRIVE_PARAMS;
		end else if (sel_floppy) begin
			// masks drop reserved bits so they keep reading zero
			unique case (cfg_index_in)
				ldor_pkg::IDX_FLOPPY_MODE_CTRL:
					fmode_reg <= cfg_wdata_in & ldor_pkg::MSK_FLOPPY_MODE;
				ldor_pkg::IDX_FLOPPY_OPTION_CTRL:
					fopt_reg <= cfg_wdata_in & ldor_pkg::MSK_FLOPPY_OPTION;
				ldor_pkg::IDX_FLOPPY_DRIVE_TYPE:
					ftype_reg <= cfg_wdata_in & ldor_pkg::MSK_DRIVE_TYPE;
				ldor_pkg::IDX_DRIVE0_PARAMS:
					drv0_reg <= cfg_wdata_in & ldor_pkg::MSK_DRIVE_PARAMS;
				ldor_pkg::IDX_DRIVE1_PARAMS:
					drv1_reg <= cfg_wdata_in & ldor_pkg::MSK_DRIVE_PARAMS;
				default: ;
			endcase
		end
	end

	// printer-port and serial-port registers
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ppmode_reg  <= ldor_pkg::RST_PP_MODE;
			ppmode2_reg <= ldor_pkg::RST_PP_MODE2;
			sp1_reg     <= ldor_pkg::RST_SERIAL_ONE;
		end else begin
			if (sel_printer && cfg_index_in == ldor_pkg::IDX_PRINTER_PORT_MODE)
				ppmode_reg <= cfg_wdata_in & ldor_pkg::MSK_PP_MODE;
			if (sel_printer && cfg_index_in == ldor_pkg::IDX_PRINTER_PORT_MODE2)
				ppmode2_reg <= cfg_wdata_in & ldor_pkg::MSK_PP_MODE2;
			if (sel_serial && cfg_index_in == ldor_pkg::IDX_SERIAL_ONE_MODE)
				sp1_reg <= cfg_wdata_in & ldor_pkg::MSK_SERIAL_ONE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read path: data is registered on the read strobe, unmapped reads give zero

	logic [7:0] rdata_next;

	always_comb begin
		rdata_next = 8'h00;
		if (cfg_ldn_in == ldor_pkg::LDN_FLOPPY) begin
			unique case (cfg_index_in)
				ldor_pkg::IDX_FLOPPY_MODE_CTRL:   rdata_next = fmode_reg;
				ldor_pkg::IDX_FLOPPY_OPTION_CTRL: rdata_next = fopt_reg;
				ldor_pkg::IDX_FLOPPY_DRIVE_TYPE:  rdata_next = ftype_reg;
				ldor_pkg::IDX_FLOPPY_RSVD_ZERO:   rdata_next = 8'h00;
				ldor_pkg::IDX_DRIVE0_PARAMS:      rdata_next = drv0_reg;
				ldor_pkg::IDX_DRIVE1_PARAMS:      rdata_next = drv1_reg;
				default:                          rdata_next = 8'h00;
			endcase
		end else if (cfg_ldn_in == ldor_pkg::LDN_PRINTER) begin
			if (cfg_index_in == ldor_pkg::IDX_PRINTER_PORT_MODE)
				rdata_next = ppmode_reg;
			else if (cfg_index_in == ldor_pkg::IDX_PRINTER_PORT_MODE2)
				rdata_next = ppmode2_reg;
		end else if (cfg_ldn_in == ldor_pkg::LDN_SERIAL1) begin
			if (cfg_index_in == ldor_pkg::IDX_SERIAL_ONE_MODE)
				rdata_next = sp1_reg;
		end
	end

	// holds the last read value between strobes
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			cfg_rdata_out <= 8'h00;
		else if (cfg_rd_in)
			cfg_rdata_out <= rdata_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// field outputs

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			floppy_enhanced_out          <= 1'b0;
			floppy_nonburst_out          <= 1'b1;
			floppy_iface_model_out       <= 2'h3;
			drive_a_type_out             <= 2'h3;
			drive_b_type_out             <= 2'h3;
			drive0_kind_select_out       <= 2'h0;
			drive0_rate_table_select_out <= 2'h0;
			drive0_precomp_disable_out   <= 1'b0;
			drive1_kind_select_out       <= 2'h0;
			drive1_rate_table_select_out <= 2'h0;
			drive1_precomp_disable_out   <= 1'b0;
			pp_mode_out                  <= ldor_pkg::PPM_PRINTER;
			pp_fifo_threshold_out        <= 4'h7;
			serial_midi_out              <= 1'b0;
			serial_high_speed_out        <= 1'b0;
		end else begin
			floppy_enhanced_out          <= fmode_reg[ldor_pkg::FM_ENHANCED];
			floppy_nonburst_out          <= fmode_reg[ldor_pkg::FM_NONBURST];
			floppy_iface_model_out       <= fmode_reg[ldor_pkg::FM_IFACE_LO +: 2];
			drive_a_type_out             <= ftype_reg[1:0];
			drive_b_type_out             <= ftype_reg[3:2];
			drive0_kind_select_out       <= drv0_reg[ldor_pkg::DP_KIND_LO +: 2];
			drive0_rate_table_select_out <= drv0_reg[ldor_pkg::DP_RATE_LO +: 2];
			drive0_precomp_disable_out   <= drv0_reg[ldor_pkg::DP_PRECOMP];
			drive1_kind_select_out       <= drv1_reg[ldor_pkg::DP_KIND_LO +: 2];
			drive1_rate_table_select_out <= drv1_reg[ldor_pkg::DP_RATE_LO +: 2];
			drive1_precomp_disable_out   <= drv1_reg[ldor_pkg::DP_PRECOMP];
			pp_mode_out                  <= ppmode_reg[ldor_pkg::PP_MODE_LO +: 3];
			pp_fifo_threshold_out        <= ppmode_reg[ldor_pkg::PP_THR_LO +: 4];
			serial_midi_out              <= sp1_reg[ldor_pkg::SP_MIDI];
			serial_high_speed_out        <= sp1_reg[ldor_pkg::SP_HISPEED];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: three stages, a change counts once stages two and three agree

	localparam int NSYNC = 6;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] pin_s1;
	logic [NSYNC-1:0] pin_s2;
	logic [NSYNC-1:0] pin_s3;
	logic [NSYNC-1:0] pin_q;

	assign pin_raw = {pp_write_protect_in_n_in, pp_drive_select_one_n_in,
		pp_drive_select_zero_n_in, write_protect_in_n_in,
		drive_select_one_n_in, drive_select_zero_n_in};

	// active-low pins idle high, so the chain resets high
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pin_s1 <= {NSYNC{1'b1}};
			pin_s2 <= {NSYNC{1'b1}};
			pin_s3 <= {NSYNC{1'b1}};
			pin_q  <= {NSYNC{1'b1}};
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			for (int i = 0; i < NSYNC; i++) begin
				if (pin_s2[i] == pin_s3[i])
					pin_q[i] <= pin_s3[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// write protect merge; the printer-port route gets the same forcing

	logic ds0_act;
	logic ds1_act;
	logic wp_pin_act;
	logic wp_next;

	assign ds0_act    = floppy_on_pp_in ? !pin_q[3] : !pin_q[0];
	assign ds1_act    = floppy_on_pp_in ? !pin_q[4] : !pin_q[1];
	assign wp_pin_act = floppy_on_pp_in ? !pin_q[5] : !pin_q[2];
	assign wp_next    = (ds0_act && fopt_reg[ldor_pkg::FO_FORCE_WP])
		|| (ds1_act && fopt_reg[ldor_pkg::FO_FORCE_WP])
		|| wp_pin_act || floppy_write_protect_in;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			core_write_protect_out <= 1'b0;
			status_reg_a_wp_out    <= 1'b0;
		end else begin
			core_write_protect_out <= wp_next;
			status_reg_a_wp_out    <= wp_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// density and floppy output drivers

	logic [1:0] dens_sel;
	assign dens_sel = fopt_reg[ldor_pkg::FO_DENS_LO +: 2];

	// printer-route pins ignore output type and tristate on purpose
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			density_out           <= 1'b0;
			floppy_pins_out       <= '0;
			floppy_pins_oe_out    <= '0;
			pp_floppy_pins_out    <= '0;
			pp_floppy_pins_oe_out <= '0;
		end else begin
			if (dens_sel == ldor_pkg::DENS_FORCE_1)
				density_out <= 1'b1;
			else if (dens_sel == ldor_pkg::DENS_FORCE_0)
				density_out <= 1'b0;
			else
				density_out <= density_core_in;
			floppy_pins_out <= floppy_core_pins_in;
			if (fmode_reg[ldor_pkg::FM_TRISTATE])
				floppy_pins_oe_out <= '0;
			else if (fmode_reg[ldor_pkg::FM_PUSHPULL])
				floppy_pins_oe_out <= '1;
			else
				floppy_pins_oe_out <= ~floppy_core_pins_in; // open drain drives lows only
			pp_floppy_pins_out    <= floppy_core_pins_in;
			pp_floppy_pins_oe_out <= {ldor_pkg::FLOPPY_PINS{floppy_on_pp_in}};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// printer-port interrupt pin

	logic pulse_mode;
	logic irq_core_d;
	assign pulse_mode = ppmode_reg[ldor_pkg::PP_IRQ_PULSE]
		&& ppmode_reg[2:0] != ldor_pkg::PPM_PRINTER
		&& ppmode_reg[2:0] != ldor_pkg::PPM_STANDARD;
	assign pp_irq_pulse_mode_out = pulse_mode;

	// pulse mode: one cycle low on a rising core request, then released
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			irq_core_d    <= 1'b0;
			pp_irq_out    <= 1'b0;
			pp_irq_oe_out <= 1'b1;
		end else begin
			irq_core_d <= pp_irq_core_in;
			if (pulse_mode) begin
				pp_irq_out    <= 1'b0;
				pp_irq_oe_out <= pp_irq_core_in && !irq_core_d;
			end else begin
				pp_irq_out    <= pp_irq_core_in;
				pp_irq_oe_out <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// timeout flag: a set arriving with a clear wins, so no event is lost

	logic rd_d;
	logic tmo_clear;
	assign tmo_clear = ppmode2_reg[ldor_pkg::PP2_TMO_SEL]
		? (rd_d && !epp_status_rd_in)
		: (epp_status_wr_in && epp_status_wdata_in);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_d                 <= 1'b0;
			epp_timeout_flag_out <= 1'b0;
		end else begin
			rd_d <= epp_status_rd_in;
			if (epp_timeout_set_in)
				epp_timeout_flag_out <= 1'b1;
			else if (tmo_clear)
				epp_timeout_flag_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// UART interrupt sharing; software leaves one UART with no IRQ

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			uart1_irq_out <= 1'b0;
			uart2_irq_out <= 1'b0;
		end else if (sp1_reg[ldor_pkg::SP_SHARE]) begin
			uart1_irq_out <= uart1_irq_in || uart2_irq_in;
			uart2_irq_out <= uart1_irq_in || uart2_irq_in;
		end else begin
			uart1_irq_out <= uart1_irq_in;
			uart2_irq_out <= uart2_irq_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	a_share_both_fire: assert property (@(posedge clk_in) disable iff (!nrst_in)
		sp1_reg[ldor_pkg::SP_SHARE] && (uart1_irq_in || uart2_irq_in)
		|=> uart1_irq_out && uart2_irq_out)
		else $error("shared uart irq not on both outputs");
	a_own_irq_split: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!sp1_reg[ldor_pkg::SP_SHARE] && uart1_irq_in && !uart2_irq_in
		|=> uart1_irq_out && !uart2_irq_out)
		else $error("unshared uart irq leaked");
	a_tristate_floppy: assert property (@(posedge clk_in) disable iff (!nrst_in)
		fmode_reg[ldor_pkg::FM_TRISTATE] |=> floppy_pins_oe_out == '0)
		else $error("floppy pins driven while tristated");
	a_pp_route_kept: assert property (@(posedge clk_in) disable iff (!nrst_in)
		floppy_on_pp_in |=> pp_floppy_pins_oe_out == '1)
		else $error("printer-route floppy pins disturbed");
	a_forced_wp: assert property (@(posedge clk_in) disable iff (!nrst_in)
		fopt_reg[ldor_pkg::FO_FORCE_WP] && ds0_act |=> core_write_protect_out
		&& status_reg_a_wp_out)
		else $error("forced write protect missing");
	a_wp_idle_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!ds0_act && !ds1_act && !wp_pin_act && !floppy_write_protect_in
		|=> !core_write_protect_out)
		else $error("write protect without cause");
	a_density_force: assert property (@(posedge clk_in) disable iff (!nrst_in)
		dens_sel == ldor_pkg::DENS_FORCE_0 |=> !density_out)
		else $error("density not forced low");
	a_irq_type_ignored: assert property (@(posedge clk_in) disable iff (!nrst_in)
		ppmode_reg[2:0] == ldor_pkg::PPM_PRINTER |-> !pp_irq_pulse_mode_out)
		else $error("irq type honoured in printer mode");
	a_tmo_set_wins: assert property (@(posedge clk_in) disable iff (!nrst_in)
		epp_timeout_set_in |=> epp_timeout_flag_out)
		else $error("timeout event lost");
	a_tmo_rd_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
		ppmode2_reg[ldor_pkg::PP2_TMO_SEL] && $fell(epp_status_rd_in)
		&& !epp_timeout_set_in |=> !epp_timeout_flag_out)
		else $error("timeout flag not cleared after read");
	a_rsvd_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(drv0_reg & ~ldor_pkg::MSK_DRIVE_PARAMS) == 8'h00 && sp1_reg[6:2] == 5'h00)
		else $error("reserved bits set");
	a_soft_reset_keeps: assert property (@(posedge clk_in) disable iff (!nrst_in)
		soft_reset_in && !cfg_wr_in |=> $stable(fmode_reg) && $stable(ppmode_reg))
		else $error("soft reset changed bank");
	c_share_event: cover property (@(posedge clk_in) disable iff (!nrst_in)
		sp1_reg[ldor_pkg::SP_SHARE] && uart2_irq_in);
	c_pulse_irq: cover property (@(posedge clk_in) disable iff (!nrst_in)
		pulse_mode && pp_irq_oe_out);
	c_tmo_clear: cover property (@(posedge clk_in) disable iff (!nrst_in)
		epp_timeout_flag_out ##1 !epp_timeout_flag_out);

endmodule // ldor_regs
`default_nettype wire

// ==== testbench/ldor_host.sv ====
// host model: drives the register port strobes at falling edges
`timescale 1ns/1ps
`default_nettype none
module ldor_host (
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	output logic      [7:0] ldn_out,
	output logic      [7:0] idx_out,
	output logic      [7:0] wdata_out,
	output logic            wr_out,
	output logic            rd_out
);
	initial begin
		{ldn_out, idx_out, wdata_out, wr_out, rd_out} = '0;
	end
	// one-cycle write; released data is inverted so a stale byte never passes
	task automatic wr(input logic [7:0] l, input logic [7:0] i, input logic [7:0] d);
		@(negedge clk_in);
		{ldn_out, idx_out, wdata_out, wr_out} = {l, i, d, 1'b1};
		@(negedge clk_in);
		{wdata_out, wr_out} = {~d, 1'b0};
	endtask
	// read strobe, then one spare cycle before the registered byte is taken
	task automatic rd(input logic [7:0] l, input logic [7:0] i, output logic [7:0] d);
		@(negedge clk_in);
		{ldn_out, idx_out, rd_out} = {l, i, 1'b1};
		@(negedge clk_in);
		{idx_out, rd_out} = {~i, 1'b0};
		@(negedge clk_in);
		d = rdata_in;
	endtask
endmodule // ldor_host
`default_nettype wire

// ==== testbench/logical_device_option_regs_test.sv ====
// testbench: reset values, masking, steering outputs and interrupt sharing
`timescale 1ns/1ps
`default_nettype none
module logical_device_option_regs_test;
	logic clk_in = 1'b0, nrst_in = 1'b0, soft_reset_in = 1'b0, cfg_wr_in, cfg_rd_in;
	logic [7:0] cfg_ldn_in, cfg_index_in, cfg_wdata_in, cfg_rdata_out, v;
	logic [3:0] floppy_core_pins_in = 4'h5, floppy_pins_out, floppy_pins_oe_out;
	logic [3:0] pp_floppy_pins_out, pp_floppy_pins_oe_out, pp_fifo_threshold_out;
	logic [2:0] pp_mode_out;
	logic [1:0] floppy_iface_model_out, drive_a_type_out, drive_b_type_out;
	logic [1:0] drive0_kind_select_out, drive0_rate_table_select_out;
	logic [1:0] drive1_kind_select_out, drive1_rate_table_select_out;
	logic floppy_enhanced_out, floppy_nonburst_out, drive0_precomp_disable_out;
	logic drive1_precomp_disable_out, floppy_on_pp_in = 1'b1, drive_select_zero_n_in = 1'b1;
	logic drive_select_one_n_in = 1'b1, write_protect_in_n_in = 1'b1;
	logic pp_drive_select_zero_n_in = 1'b1, pp_drive_select_one_n_in = 1'b1;
	logic pp_write_protect_in_n_in = 1'b1, floppy_write_protect_in = 1'b0;
	logic core_write_protect_out, status_reg_a_wp_out, density_core_in = 1'b1, density_out;
	logic pp_irq_pulse_mode_out, pp_irq_core_in = 1'b0, pp_irq_out, pp_irq_oe_out;
	logic epp_timeout_set_in = 1'b0, epp_status_wr_in = 1'b0, epp_status_wdata_in = 1'b0;
	logic epp_status_rd_in = 1'b0, epp_timeout_flag_out, serial_midi_out, serial_high_speed_out;
	logic uart1_irq_in = 1'b0, uart2_irq_in = 1'b0, uart1_irq_out, uart2_irq_out;
	int failures = 0, n_checks = 0;
	// device, index, reset value, writable mask of every bank location
	localparam logic [31:0] T [9] = '{32'h00f00ecf, 32'h00f1000d, 32'h00f2ffff, 32'h00f30000,
		32'h00f4005b, 32'h00f5005b, 32'h03f03cff, 32'h03f10010, 32'h04f00083};
	always #4 clk_in = ~clk_in;
	ldor_host u_host (.clk_in(clk_in), .rdata_in(cfg_rdata_out), .ldn_out(cfg_ldn_in),
		.idx_out(cfg_index_in), .wdata_out(cfg_wdata_in), .wr_out(cfg_wr_in), .rd_out(cfg_rd_in));
	ldor_regs u_dut (.*);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] l, input logic [7:0] i, input logic [7:0] e);
		u_host.rd(l, i, v);
		chk(v, e);
	endtask
	// pins pass a synchroniser, so allow eight cycles before looking
	task automatic w8();
		repeat (8) @(negedge clk_in);
	endtask
	task automatic conclude();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(negedge clk_in);
		nrst_in = 1'b1;
		for (int k = 0; k < 9; k++) rchk(T[k][31:24], T[k][23:16], T[k][15:8]);
		for (int k = 0; k < 9; k++) u_host.wr(T[k][31:24], T[k][23:16], 8'hff);
		soft_reset_in = 1'b1; // soft reset must leave the bank as written
		for (int k = 0; k < 9; k++) rchk(T[k][31:24], T[k][23:16], T[k][7:0]);
		$display("test reset_and_mask done");
		chk({floppy_pins_oe_out, pp_floppy_pins_oe_out}, 8'h0f);
		chk({pp_floppy_pins_out, pp_floppy_pins_oe_out}, 8'h5f);
		chk({4'h0, drive0_rate_table_select_out, drive0_kind_select_out}, 8'h0f);
		chk({4'h0, drive1_rate_table_select_out, drive1_kind_select_out}, 8'h0f);
		chk({6'h0, drive0_precomp_disable_out, drive1_precomp_disable_out}, 8'h03);
		chk({7'h0, density_out}, 8'h00);
		chk({7'h0, pp_irq_pulse_mode_out}, 8'h01);
		uart1_irq_in = 1'b1; // uart2 stays silent: one irq owner while shared
		w8();
		chk({6'h0, uart1_irq_out, uart2_irq_out}, 8'h03);
		chk({6'h0, serial_midi_out, serial_high_speed_out}, 8'h03);
		{floppy_on_pp_in, drive_select_zero_n_in} = 2'b00; // own route first, printer route next
		w8();
		chk({7'h0, core_write_protect_out}, 8'h01);
		{floppy_on_pp_in, drive_select_zero_n_in, pp_drive_select_one_n_in} = 3'b110;
		w8();
		chk({6'h0, core_write_protect_out, status_reg_a_wp_out}, 8'h03);
		$display("test outputs_all_ones done");
		u_host.wr(8'h04, 8'hf0, 8'h00);
		u_host.wr(8'h03, 8'hf0, 8'h84);
		density_core_in = 1'b0;
		u_host.wr(8'h00, 8'hf1, 8'h08);
		u_host.wr(8'h00, 8'hf0, 8'h00);
		w8();
		chk({6'h0, uart1_irq_out, uart2_irq_out}, 8'h02);
		chk({7'h0, pp_irq_pulse_mode_out}, 8'h00);
		chk({7'h0, density_out}, 8'h01);
		chk({floppy_pins_out, floppy_pins_oe_out}, 8'h5a);
		u_host.wr(8'h03, 8'hf0, 8'h80);
		u_host.wr(8'h00, 8'hf1, 8'h04);
		u_host.wr(8'h00, 8'hf0, 8'h40);
		w8();
		chk({7'h0, pp_irq_pulse_mode_out}, 8'h00);
		chk({6'h0, density_out, core_write_protect_out}, 8'h00);
		chk({floppy_pins_out, floppy_pins_oe_out}, 8'h5f);
		$display("test modes done");
		epp_timeout_set_in = 1'b1;
		@(negedge clk_in) {epp_timeout_set_in, epp_status_rd_in} = 2'b01;
		chk({7'h0, epp_timeout_flag_out}, 8'h01);
		@(negedge clk_in) epp_status_rd_in = 1'b0;
		@(negedge clk_in) chk({7'h0, epp_timeout_flag_out}, 8'h00);
		u_host.wr(8'h03, 8'hf1, 8'h00);
		{epp_timeout_set_in, epp_status_wr_in, epp_status_wdata_in} = 3'b111; // set wins
		@(negedge clk_in) epp_timeout_set_in = 1'b0;
		chk({7'h0, epp_timeout_flag_out}, 8'h01);
		@(negedge clk_in) epp_status_wr_in = 1'b0;
		chk({7'h0, epp_timeout_flag_out}, 8'h00);
		u_host.wr(8'h03, 8'hf0, 8'h82);
		pp_irq_core_in = 1'b1;
		@(negedge clk_in) chk({6'h0, pp_irq_out, pp_irq_oe_out}, 8'h01);
		@(negedge clk_in) chk({6'h0, pp_irq_out, pp_irq_oe_out}, 8'h00);
		chk({1'b0, pp_fifo_threshold_out, pp_mode_out}, 8'h02);
		$display("test timeout_and_pulse done");
		nrst_in = 1'b0;
		@(negedge clk_in);
		nrst_in = 1'b1;
		rchk(8'h00, 8'hf0, 8'h0e);
		chk({1'b0, pp_fifo_threshold_out, pp_mode_out}, 8'h3c);
		chk({4'h0, drive_a_type_out, drive_b_type_out}, 8'h0f);
		chk({7'h0, floppy_nonburst_out}, 8'h01);
		chk({5'h0, floppy_enhanced_out, floppy_iface_model_out}, 8'h03);
		conclude();
	end
endmodule // logical_device_option_regs_test
`default_nettype wire
